// ### rtl/cm_monitor.sv
// Functional notes
// RULE1 - sample the main clock with the internal oscillator; request reset on loss
// RULE2 - enable flag, once set, cannot be cleared by software writes
// RULE3 - a monitor-caused reset sets the monitor reset flag in reset source
// RULE4 - writing 1 to the enable flag starts monitoring
// RULE5 - no checking during oscillation stabilisation after stop release
// RULE6 - no checking from main stop bit set until source status returns to 0; code suspends only while the bit is 1 or main is inactive with status 1
// RULE7 - no checking while the internal oscillator is stopped
// RULE8 - no checking while the cpu runs from the internal oscillator
// RULE9 - checking continues in halt and idle modes; stops in stop and reset
// RULE10 - in sub-idle, check when main stop bit is 0, stop when it is 1
// RULE11 - software stops the internal oscillator with the stop bit
// RULE12 - stop writes are ignored while the cpu runs on the internal oscillator
// RULE13 - loss is no main edge within a fixed tick count; one reset request
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
module cm_monitor #(
	parameter int SAMPLE_DIV = cm_pkg::SAMPLE_DIV, // cycles per sampling tick
	parameter int LOSS_TICKS = cm_pkg::LOSS_TICKS  // ticks counted as loss
) (
	input  wire logic        i_clock,        // 250 mhz system clock
	input  wire logic        i_rst_n,        // synchronous reset, low
	input  wire logic        i_psel,         // apb select
	input  wire logic        i_penable,      // apb enable
	input  wire logic        i_pwrite,       // apb direction
	input  wire logic [7:0]  i_paddr,        // apb byte address
	input  wire logic [31:0] i_pwdata,       // apb write data
	input  wire logic [3:0]  i_pstrb,        // apb byte strobes
	output logic      [31:0] o_prdata,       // apb read data
	output logic             o_pready,       // apb ready
	output logic             o_pslverr,      // apb error
	input  wire logic        i_main_clk,     // main clock pin
	input  wire logic        i_main_running, // main clock source active
	input  wire logic [1:0]  i_cpu_clk_sel,  // cpu clock source code
	input  wire logic [2:0]  i_power_mode,   // current power mode
	input  wire logic        i_osc_stab,     // stabilisation count running
	input  wire logic        i_warm_reset,   // reset by the reset controller
	input  wire logic        i_cm_reset_src, // last reset came from monitor
	output logic             o_rst_req,      // reset request to controller
	output logic             o_int_osc_stop, // stop the internal oscillator
	output logic             o_main_osc_stop,// stop the main oscillator
	output logic             o_irq           // level interrupt
);
	typedef struct packed {
		logic        mon_en;     // monitor_enable_flag
		logic        mon_rst;    // monitor_reset_flag
		logic        mosc_stop;  // main_osc_stop_bit
		logic        iosc_stop;  // internal_osc_stop_bit
		logic [31:0] mask;       // interrupt mask
		logic [cm_pkg::EV_W-1:0] ist; // sticky status
		logic [1:0]  mck_s;      // main clock synchroniser
		logic        mck_last;   // previous synchronised level
		logic        edge_seen;  // main edge since last tick
		logic [7:0]  div;        // sampling tick divider
		logic [7:0]  miss;       // ticks with no main edge
		logic        rst_req;    // reset request level
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
		logic        src_init;   // reset source captured once
	} cm_state_t;

	cm_state_t s_q;
	cm_state_t s_d;
	logic      csrc;
	logic      on_int;
	logic      active;
	logic      tick;
	logic      wr_acc;
	logic      rd_acc;
	logic      loss;
	logic [31:0] wmask;

	// expand byte strobes to a bit mask
	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// source status is 1 while the main clock is not the cpu source
	assign csrc   = (i_cpu_clk_sel != 2'(cm_pkg::CM_CPU_MAIN));
	assign on_int = (i_cpu_clk_sel == 2'(cm_pkg::CM_CPU_INT));
	assign wr_acc = i_psel & i_penable & i_pwrite & ~s_q.pready;
	assign rd_acc = i_psel & i_penable & ~i_pwrite & ~s_q.pready;
	assign wmask  = strb_mask(i_pstrb);
	assign tick   = (s_q.div == 8'(SAMPLE_DIV - 1));

	// checking is gated by every automatic stop condition
	always_comb
	begin
		active = s_q.mon_en;                           // see RULE4
		if (i_osc_stab)
			active = 1'b0;                             // see RULE5
		if (s_q.mosc_stop || (!i_main_running && csrc))
			active = 1'b0;                             // see RULE6
		if (i_power_mode == 3'(cm_pkg::CM_SIDLE) && s_q.mosc_stop)
			active = 1'b0;                             // see RULE10
		if (s_q.iosc_stop)
			active = 1'b0;                             // see RULE7
		if (on_int)
			active = 1'b0;                             // see RULE8
		if (i_power_mode == 3'(cm_pkg::CM_STOP))
			active = 1'b0;                             // see RULE9
	end

	// halt and idle modes leave active untouched, see RULE9
	assign loss = active && tick && !s_q.edge_seen
		&& (s_q.miss == 8'(LOSS_TICKS - 1));      // see RULE13

	// single next-state process
	always_comb
	begin
		s_d = s_q;
		s_d.pready  = 1'b0;
		s_d.pslverr = 1'b0;
		// two flops before the main clock level is used
		s_d.mck_s    = {s_q.mck_s[0], i_main_clk};
		s_d.mck_last = s_q.mck_s[1];
		if (s_q.mck_s[1] != s_q.mck_last)
			s_d.edge_seen = 1'b1;                      // see RULE1
		s_d.div = tick ? 8'h00 : s_q.div + 8'h01;
		// a tick closes one sampling window of the internal oscillator
		if (tick)
		begin
			s_d.edge_seen = 1'b0;
			if (!active || s_q.edge_seen)
				s_d.miss = 8'h00;
			else if (s_q.miss != 8'(LOSS_TICKS - 1))
				s_d.miss = s_q.miss + 8'h01;
		end
		// request is held until reset; a pulse could be missed
		if (loss)
			s_d.rst_req = 1'b1;                        // see RULE13
		// monitor-caused reset, seen once after release
		if (!s_q.src_init)
		begin
			s_d.src_init = 1'b1;
			s_d.mon_rst  = i_cm_reset_src;             // see RULE3
		end
		// register writes
		if (wr_acc)
		begin
			s_d.pready = 1'b1;
			case (i_paddr)
				cm_pkg::MODE_OFF:
					if (i_pstrb[0] && i_pwdata[cm_pkg::MON_EN_BIT])
						s_d.mon_en = 1'b1;             // see RULE2
				cm_pkg::RSRC_OFF:
					if (i_pstrb[0] && i_pwdata[cm_pkg::MON_RST_BIT])
						s_d.mon_rst = 1'b0;
				cm_pkg::PCC_OFF:
					if (i_pstrb[0])
						s_d.mosc_stop = i_pwdata[cm_pkg::MOSC_BIT];
				cm_pkg::OSC_OFF:
					if (i_pstrb[0] && !on_int)         // see RULE12
						s_d.iosc_stop = i_pwdata[cm_pkg::IOSC_BIT]; // see RULE11
				cm_pkg::IST_OFF:
					s_d.ist = s_q.ist
						& ~(i_pwdata[cm_pkg::EV_W-1:0] & wmask[cm_pkg::EV_W-1:0]);
				cm_pkg::IMSK_OFF:
					s_d.mask = (s_q.mask & ~wmask) | (i_pwdata & wmask);
				cm_pkg::STAT_OFF:
					s_d.pslverr = 1'b0;
				default:
					s_d.pslverr = 1'b1;
			endcase
		end
		// reads answer one cycle after the access phase begins
		if (rd_acc)
		begin
			s_d.pready = 1'b1;
			s_d.prdata = 32'h0000_0000;
			case (i_paddr)
				cm_pkg::MODE_OFF:
					s_d.prdata[cm_pkg::MON_EN_BIT] = s_q.mon_en;
				cm_pkg::RSRC_OFF:
					s_d.prdata[cm_pkg::MON_RST_BIT] = s_q.mon_rst;
				cm_pkg::PCC_OFF:
				begin
					s_d.prdata[cm_pkg::MOSC_BIT] = s_q.mosc_stop;
					s_d.prdata[cm_pkg::CSRC_BIT] = csrc;
				end
				cm_pkg::OSC_OFF:
					s_d.prdata[cm_pkg::IOSC_BIT] = s_q.iosc_stop;
				cm_pkg::IST_OFF:
					s_d.prdata[cm_pkg::EV_W-1:0] = s_q.ist;
				cm_pkg::IMSK_OFF:
					s_d.prdata = s_q.mask;
				cm_pkg::STAT_OFF:
					s_d.prdata = {23'h000000, s_q.miss, active};
				default:
					s_d.pslverr = 1'b1;
			endcase
		end
		// events set after clears so a same-cycle event wins
		if (loss)
			s_d.ist[cm_pkg::EV_LOSS_BIT] = 1'b1;
		if (wr_acc && i_paddr == cm_pkg::MODE_OFF && i_pstrb[0]
			&& i_pwdata[cm_pkg::MON_EN_BIT] && !s_q.mon_en)
			s_d.ist[cm_pkg::EV_START_BIT] = 1'b1;
		s_d.irq = |(s_d.ist & s_d.mask[cm_pkg::EV_W-1:0]);
	end

	// state register; reset stops the monitor too, see RULE9
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n || i_warm_reset)
		begin
			s_q <= '0;
			s_q.mask <= cm_pkg::MASK_RST;
		end
		else
			s_q <= s_d;
	end

	assign o_prdata        = s_q.prdata;
	assign o_pready        = s_q.pready;
	assign o_pslverr       = s_q.pslverr;
	assign o_rst_req       = s_q.rst_req;
	assign o_int_osc_stop  = s_q.iosc_stop;
	assign o_main_osc_stop = s_q.mosc_stop;
	assign o_irq           = s_q.irq;
endmodule

// ### rtl/cm_pkg.sv
package cm_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] MODE_OFF   = 8'h00; // clock_monitor_mode_reg
	localparam logic [7:0] RSRC_OFF   = 8'h04; // reset_source_reg
	localparam logic [7:0] PCC_OFF    = 8'h08; // processor_clock_ctrl_reg
	localparam logic [7:0] OSC_OFF    = 8'h0c; // internal_osc_ctrl_reg
	localparam logic [7:0] IST_OFF    = 8'h10; // interrupt status
	localparam logic [7:0] IMSK_OFF   = 8'h14; // interrupt mask
	localparam logic [7:0] STAT_OFF   = 8'h18; // live monitor state
	// field positions
	localparam int MON_EN_BIT   = 0; // monitor_enable_flag
	localparam int MON_RST_BIT  = 0; // monitor_reset_flag
	localparam int MOSC_BIT     = 0; // main_osc_stop_bit
	localparam int CSRC_BIT     = 1; // clock_source_status_bit
	localparam int IOSC_BIT     = 0; // internal_osc_stop_bit
	// event bits: 0 main clock loss detected, 1 monitor started
	localparam int EV_LOSS_BIT  = 0;
	localparam int EV_START_BIT = 1;
	localparam int EV_W         = 2;
	// reset values
	localparam logic [31:0] MASK_RST = 32'h0000_0000;
	// sampling tick of the internal oscillator and loss window
	localparam int  SAMPLE_DIV   = 8;  // clock cycles per sampling tick
	localparam int  LOSS_TICKS   = 4;  // ticks without a main clock edge
	localparam int  SLVERR_NONE  = 0;
	// cpu clock selection codes
	typedef enum logic [1:0] {
		CM_CPU_MAIN = 2'b00,
		CM_CPU_SUB  = 2'b01,
		CM_CPU_INT  = 2'b10
	} cm_cpu_clk_t;
	// power modes
	typedef enum logic [2:0] {
		CM_RUN   = 3'b000,
		CM_HALT  = 3'b001,
		CM_IDLE1 = 3'b010,
		CM_IDLE2 = 3'b011,
		CM_STOP  = 3'b100,
		CM_SIDLE = 3'b101
	} cm_pmode_t;
endpackage

// ### test/cm_clkgen_model.sv
`timescale 1ns/1ps
// main oscillator; a fault silences the pin but leaves the enable up
module cm_clkgen_model (
	input  wire logic i_clock,         // system clock
	input  wire logic i_fail,          // crystal fault
	input  wire logic i_main_osc_stop, // stop request
	output logic      o_main_clk,      // main clock pin
	output logic      o_main_running   // generator enabled
);
	logic [1:0] cnt_q = 2'h0;
	logic       clk_q = 1'b0;
	assign o_main_running = !i_main_osc_stop;
	assign o_main_clk     = clk_q;
	// toggle every third cycle, unrelated to the sampling tick
	always_ff @(posedge i_clock)
	begin
		cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
		if (cnt_q == 2'h2 && o_main_running && !i_fail)
			clk_q <= !clk_q;
	end
endmodule

// ### test/cm_monitor_assertions.sv
`timescale 1ns/1ps
// sees the monitor pins; suspend rules are judged at each new reset request
module cm_monitor_assertions (
	input wire logic       i_clock,        // clock
	input wire logic       i_rst_n,        // reset
	input wire logic       i_psel,         // apb select
	input wire logic       i_penable,      // apb enable
	input wire logic [1:0] i_cpu_clk_sel,  // cpu source
	input wire logic [2:0] i_power_mode,   // power mode
	input wire logic       i_osc_stab,     // stabilising
	input wire logic       i_warm_reset,   // device reset
	input wire logic       o_pready,       // apb ready
	input wire logic       o_rst_req,      // reset request
	input wire logic       o_int_osc_stop, // internal stop
	input wire logic       o_main_osc_stop // main stop
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	sequence s_acc; i_psel && i_penable && !o_pready; endsequence
	sequence s_req; $rose(o_rst_req); endsequence
	property p_ack; s_acc |=> o_pready; endproperty
	property p_pulse; o_pready |=> !o_pready; endproperty
	property p_hold; o_rst_req && !i_warm_reset |=> o_rst_req; endproperty
	property p_clr; i_warm_reset |=> !o_rst_req; endproperty
	property p_stab; s_req |-> !$past(i_osc_stab); endproperty
	property p_cpu; s_req |-> $past(i_cpu_clk_sel) != 2'b10; endproperty
	property p_mode; s_req |-> $past(i_power_mode) != 3'b100; endproperty
	property p_iosc; s_req |-> !$past(o_int_osc_stop); endproperty
	property p_mosc; s_req |-> !$past(o_main_osc_stop); endproperty
	property p_lock;
		$rose(o_int_osc_stop) |-> $past(i_cpu_clk_sel) != 2'b10;
	endproperty
	a_ack: assert property (p_ack) else $error("late ready");
	a_pulse: assert property (p_pulse) else $error("long ready");
	a_hold: assert property (p_hold) else $error("req dropped");
	a_clr: assert property (p_clr) else $error("req kept");
	a_stab: assert property (p_stab) else $error("req in stab");
	a_cpu: assert property (p_cpu) else $error("req on int");
	a_mode: assert property (p_mode) else $error("req in stop");
	a_iosc: assert property (p_iosc) else $error("req osc off");
	a_mosc: assert property (p_mosc) else $error("req main off");
	a_lock: assert property (p_lock) else $error("osc stopped");
endmodule
bind cm_monitor cm_monitor_assertions i_chk (.*);

// ### test/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
	n_fail++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
	logic        clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, stab = 1'b0, warm = 1'b0, src = 1'b1;
	logic        fail = 1'b0, pready, pslverr, main_clk, main_run;
	logic        req, iosc, mosc, irq, err_q;
	logic [1:0]  cpu_sel = 2'b00;
	logic [2:0]  pmode = 3'b000;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_q;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          k, w;
	always #2 clock = !clock;
	// short tick and window keep each loss test near a dozen cycles
	cm_monitor #(.SAMPLE_DIV(4), .LOSS_TICKS(2)) i_dut (.i_clock(clock),
		.i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_main_clk(main_clk), .i_main_running(main_run),
		.i_cpu_clk_sel(cpu_sel), .i_power_mode(pmode), .i_osc_stab(stab),
		.i_warm_reset(warm), .i_cm_reset_src(src), .o_rst_req(req),
		.o_int_osc_stop(iosc), .o_main_osc_stop(mosc), .o_irq(irq));
	cm_clkgen_model i_far (.i_clock(clock), .i_fail(fail),
		.i_main_osc_stop(mosc), .o_main_clk(main_clk),
		.o_main_running(main_run));
	// one apb transfer; ready and read data are taken at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd_q  = prdata;
		err_q = pslverr;
		if (n >= 20)
			n_fail++;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("read", e, rd_q)
	endtask
	task automatic wrap_up;
		if (n_fail == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// watchdog well past the several hundred cycles of the tests
	initial
	begin
		repeat (20000) @(posedge clock);
		n_fail++;
		wrap_up();
	end
	initial
	begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		rd(cm_pkg::RSRC_OFF, 32'h1);
		src <= 1'b0;
		apb(1'b1, cm_pkg::RSRC_OFF, 32'h1);
		rd(cm_pkg::RSRC_OFF, 32'h0);
		rd(8'h40, 32'h0);
		`CHK("slverr", 1'b1, err_q)
		rd(cm_pkg::MODE_OFF, 32'h0);
		apb(1'b1, cm_pkg::MODE_OFF, 32'h1);
		rd(cm_pkg::MODE_OFF, 32'h1);
		apb(1'b1, cm_pkg::MODE_OFF, 32'h0);
		rd(cm_pkg::MODE_OFF, 32'h1);
		apb(1'b1, cm_pkg::IMSK_OFF, 32'h2);
		`CHK("irq", 1'b1, irq)
		apb(1'b1, cm_pkg::IST_OFF, 32'h2);
		`CHK("irq", 1'b0, irq)
		// stabilisation, int cpu, stop mode and both osc stop bits must each hide a dead main clock
		for (k = 0; k < 5; k++)
		begin
			case (k)
				0: stab <= 1'b1;
				1: cpu_sel <= 2'b10;
				2: pmode <= 3'b100;
				3: apb(1'b1, cm_pkg::OSC_OFF, 32'h1);
				default: apb(1'b1, cm_pkg::PCC_OFF, 32'h1);
			endcase
			fail <= 1'b1;
			repeat (80) @(posedge clock);
			`CHK("req", 1'b0, req)
			if (k == 3)
				`CHK("iosc", 1'b1, iosc)
			{fail, stab, cpu_sel, pmode} <= 7'h0;
			apb(1'b1, cm_pkg::OSC_OFF, 32'h0);
			apb(1'b1, cm_pkg::PCC_OFF, 32'h0);
		end
		cpu_sel <= 2'b10;
		apb(1'b1, cm_pkg::OSC_OFF, 32'h1);
		rd(cm_pkg::OSC_OFF, 32'h0);
		cpu_sel <= 2'b00;
		// real loss in halt, idle1, idle2 and sub-idle
		for (k = 0; k < 4; k++)
		begin
			pmode   <= (k == 3) ? 3'h5 : 3'(k + 1);
			cpu_sel <= (k == 3) ? 2'b01 : 2'b00;
			apb(1'b1, cm_pkg::IMSK_OFF, 32'h1);
			fail <= 1'b1;
			for (w = 0; w < 60 && req !== 1'b1; w++)
				@(posedge clock);
			`CHK("req", 1'b1, req)
			`CHK("irq", 1'b1, irq)
			warm <= 1'b1;
			fail <= 1'b0;
			src  <= 1'b1;
			@(posedge clock);
			warm <= 1'b0;
			@(posedge clock);
			`CHK("req", 1'b0, req)
			src <= 1'b0;
			rd(cm_pkg::RSRC_OFF, 32'h1);
			apb(1'b1, cm_pkg::RSRC_OFF, 32'h1);
			apb(1'b1, cm_pkg::MODE_OFF, 32'h1);
		end
		wrap_up();
	end
endmodule
